/* File: bdc_defs.svh */
// Register map, field positions, reset values and timing figures of the dimming control
`ifndef BDC_DEFS_SVH
`define BDC_DEFS_SVH

// Register offsets
`define BDC_REG_MODE    8'h02
`define BDC_REG_IFS     8'h03
`define BDC_REG_BRT_LO  8'h06
`define BDC_REG_BRT_HI  8'h07
`define BDC_REG_PWM     8'h08

// Reset values
`define BDC_RST_MODE    8'h00
`define BDC_RST_IFS     8'h9F
`define BDC_RST_BRT     8'h00
`define BDC_RST_PWM     8'h00

// Field positions
`define BDC_F_STATE     1:0
`define BDC_F_FLASH     1
`define BDC_F_EXP       2
`define BDC_F_PWMEN     4
`define BDC_F_RATE      7:6
`define BDC_F_HYST      4:2
`define BDC_F_IFS       7:3
`define BDC_F_CHAN      2:0
`define BDC_F_LSB       2:0

// Rate field codes
`define BDC_RATE_800K   2'h0
`define BDC_RATE_4M     2'h1

// Bus slave address
`define BDC_SLAVE_ADDR  7'h36

// Code arithmetic
`define BDC_CODE_MAX    11'h7FF
`define BDC_EXP_K       20'h0_0115
`define BDC_EXP_GAIN    12'h51E

// Clock and timing figures
`define BDC_CLK_NS      5
`define BDC_CLK_KHZ     200000
`define BDC_SMP_KHZ_24  24000
`define BDC_SMP_KHZ_4   4000
`define BDC_SMP_KHZ_08  800
`define BDC_TRESET_NS   250000
`define BDC_TMO_24_NS   680000
`define BDC_TMO_4_NS    4100000
`define BDC_TMO_08_NS   20500000
`define BDC_RAMP_NS     8000000
`define BDC_RAMP_STEPS  7'h40

`endif

/* File: bdc_pkg.sv */
// Types shared by the dimming control and its serial register slave
package bdc_pkg;

  typedef enum logic [2:0] {
    BDC_I2C_IDLE,
    BDC_I2C_RX,
    BDC_I2C_ACK,
    BDC_I2C_TX,
    BDC_I2C_TXACK
  } bdc_i2c_st_t;

  typedef struct packed {
    bdc_i2c_st_t st;
    logic [3:0]  bitc;
    logic [7:0]  sh;
    logic [1:0]  phase;
    logic        rw;
    logic [7:0]  ptr;
    logic        sda_low;
    logic        scl_p;
    logic        sda_p;
    logic        wr;
    logic [7:0]  waddr;
    logic [7:0]  wdata;
  } bdc_i2c_regs_t;

  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  full_scale_current;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [7:0]  pwmc;
    logic [10:0] code;
    logic [15:0] por_cnt;
    logic        i2c_ok;
    logic [7:0]  smp_cnt;
    logic        pwm_p;
    logic [19:0] hi_cnt;
    logic [19:0] per_cnt;
    logic [21:0] tmo_cnt;
    logic        timed_out;
    logic        busy;
    logic [3:0]  bit_i;
    logic [30:0] rem;
    logic [19:0] dvs;
    logic [10:0] quo;
    logic [10:0] duty_h;
    logic        dir_up;
    logic [10:0] level;
    logic [10:0] ramp_base;
    logic [6:0]  ramp_left;
    logic [15:0] ramp_cnt;
    logic        active_p;
  } bdc_ctl_regs_t;

endpackage

/* File: bdc_i2c_slave.sv */
// Serial register slave: address match, register pointer, writes and auto-increment reads
`timescale 1ns/100ps
`default_nettype none
`include "bdc_defs.svh"

module bdc_i2c_slave (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       enable_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic [7:0] rd_data_in,
  output logic [7:0]      rd_addr_out,
  output logic            wr_stb_out,
  output logic [7:0]      wr_addr_out,
  output logic [7:0]      wr_data_out
);

  bdc_pkg::bdc_i2c_regs_t q;
  bdc_pkg::bdc_i2c_regs_t d;

  // Open drain: only ever pulls low
  assign sda_out     = 1'b0;
  assign sda_oe_out  = q.sda_low;
  assign rd_addr_out = q.ptr;
  assign wr_stb_out  = q.wr;
  assign wr_addr_out = q.waddr;
  assign wr_data_out = q.wdata;

  // Bus edges seen through the previous samples of both lines
  always_comb begin
    d       = q;
    d.wr    = 1'b0;
    d.scl_p = scl_in;
    d.sda_p = sda_in;
    if (q.scl_p && scl_in && q.sda_p && !sda_in) begin
      d.st      = bdc_pkg::BDC_I2C_RX;
      d.bitc    = 4'h0;
      d.phase   = 2'h0;
      d.sda_low = 1'b0;
    end else if (q.scl_p && scl_in && !q.sda_p && sda_in) begin
      d.st      = bdc_pkg::BDC_I2C_IDLE;
      d.sda_low = 1'b0;
    end else if (!q.scl_p && scl_in) begin
      case (q.st)
        bdc_pkg::BDC_I2C_RX: begin
          d.sh   = {q.sh[6:0], sda_in};
          d.bitc = q.bitc + 4'h1;
        end
        bdc_pkg::BDC_I2C_TXACK: begin
          if (sda_in) begin
            d.st = bdc_pkg::BDC_I2C_IDLE; // Master ends the read
          end else begin
            d.st  = bdc_pkg::BDC_I2C_ACK;
            d.ptr = q.ptr + 8'h01;
          end
        end
        default: begin
        end
      endcase
    end else if (q.scl_p && !scl_in) begin
      case (q.st)
        bdc_pkg::BDC_I2C_RX: begin
          if (q.bitc == 4'h8) begin
            d.st      = bdc_pkg::BDC_I2C_ACK;
            d.sda_low = 1'b1;
            case (q.phase)
              2'h0: begin
                if (q.sh[7:1] == `BDC_SLAVE_ADDR) begin
                  d.rw = q.sh[0];
                end else begin
                  d.st      = bdc_pkg::BDC_I2C_IDLE; // Not ours: stay silent
                  d.sda_low = 1'b0;
                end
              end
              2'h1: d.ptr = q.sh;
              default: begin
                d.wr    = 1'b1;
                d.waddr = q.ptr;
                d.wdata = q.sh;
                d.ptr   = q.ptr + 8'h01;
              end
            endcase
          end
        end
        bdc_pkg::BDC_I2C_ACK: begin
          d.bitc = 4'h0;
          if (q.rw) begin
            d.st      = bdc_pkg::BDC_I2C_TX;
            d.sh      = rd_data_in;
            d.sda_low = !rd_data_in[7];
          end else begin
            d.st      = bdc_pkg::BDC_I2C_RX;
            d.sda_low = 1'b0;
            if (q.phase != 2'h2) begin
              d.phase = q.phase + 2'h1;
            end
          end
        end
        bdc_pkg::BDC_I2C_TX: begin
          if (q.bitc == 4'h7) begin
            d.st      = bdc_pkg::BDC_I2C_TXACK;
            d.sda_low = 1'b0;
          end else begin
            d.bitc    = q.bitc + 4'h1;
            d.sh      = {q.sh[6:0], 1'b0};
            d.sda_low = !q.sh[6];
          end
        end
        default: begin
        end
      endcase
    end
    // Disabled interface answers nothing and forgets any partial transfer
    if (!enable_in) begin
      d = '0;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule
`default_nettype wire

/* File: bdc_ctl.sv */
// Backlight dimming control: registers, operating state, brightness mapping, PWM duty sensing
//
// Function
// (RQ1) Enable pin low: shutdown, all registers to defaults, serial interface ignored.
// (RQ2) Enable high gives standby; interface usable 250 us after supply reset releases.
// (RQ3) Enable pin low cuts LED current at once, without ramp.
// (RQ4) Leaving backlight or flash by command ramps current down over fixed time.
// (RQ5) Mode bits 1:0 pick standby, backlight or flash; reset to standby.
// (RQ6) Brightness code is high byte register over low three bits register.
// (RQ7) Host writes low bits first, then high byte.
// (RQ8) New brightness takes effect only when the high byte is written.
// (RQ9) Mode bit 2 picks linear or exponential code to current mapping.
// (RQ10) Linear: current is full scale times duty times code over 2047.
// (RQ11) Exponential: full scale times duty times 1.002931237 to the code, over 400.
// (RQ12) Code zero turns off all sinks and the boost.
// (RQ13) Measured duty used only with PWM dimming on; otherwise duty is one.
// (RQ14) Mode bit 4 enables PWM dimming; duty becomes an 11-bit code.
// (RQ15) PWM pin sampled at 24 MHz, 4 MHz or 800 kHz per control bits 7:6. The code samples at 25 MHz, not 24 MHz.
// (RQ16) Flash current ignores the measured PWM duty.
// (RQ17) Hysteresis only on direction reversal; same direction passes freely.
// (RQ18) Control bits 4:2 give the hysteresis in duty LSBs, zero to seven.
// (RQ19) With PWM dimming on and no pulse for the timeout, boost turns off. The code keeps the boost on in flash.
// (RQ20) Timeout is 20.5 ms, 4.1 ms or 0.68 ms per sample rate.
// (RQ21) Host PWM must run between 50 Hz and 50 kHz.
// (RQ22) Host keeps PWM below 390 Hz, 1.95 kHz or 11.7 kHz for full resolution.
// (RQ23) Full-scale current code comes from register 0x03 bits 7:3.
`timescale 1ns/100ps
`default_nettype none
`include "bdc_defs.svh"

module bdc_ctl #(
  parameter int TRESET_CYC    = (`BDC_TRESET_NS + `BDC_CLK_NS - 1) / `BDC_CLK_NS,
  parameter int TMO_CYC_24    = `BDC_TMO_24_NS / `BDC_CLK_NS,
  parameter int TMO_CYC_4     = `BDC_TMO_4_NS / `BDC_CLK_NS,
  parameter int TMO_CYC_08    = `BDC_TMO_08_NS / `BDC_CLK_NS,
  parameter int RAMP_STEP_CYC = `BDC_RAMP_NS / `BDC_CLK_NS / 64
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        hw_enable_pin_in,
  input  wire logic        supply_por_n_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic        pwm_in,
  output logic [10:0]      led_level_out,
  output logic [4:0]       full_scale_current_out,
  output logic [2:0]       sink_enable_out,
  output logic             boost_enable_out,
  output logic             backlight_mode_out,
  output logic             flash_mode_out
);

  localparam int SMP_DIV_24 = `BDC_CLK_KHZ / `BDC_SMP_KHZ_24;
  localparam int SMP_DIV_4  = `BDC_CLK_KHZ / `BDC_SMP_KHZ_4;
  localparam int SMP_DIV_08 = `BDC_CLK_KHZ / `BDC_SMP_KHZ_08;

  bdc_pkg::bdc_ctl_regs_t q;
  bdc_pkg::bdc_ctl_regs_t d;

  logic        i2c_en;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        active;
  logic        flash;
  logic        pwm_en;
  logic [10:0] eff_duty;
  logic [10:0] base;
  logic [10:0] target;
  logic [19:0] exp_t;
  logic [16:0] exp_m;
  logic [28:0] exp_p;
  logic [21:0] prod;
  logic [21:0] prod_n;
  logic [7:0]  smp_lim;
  logic [21:0] tmo_lim;

  // Defaults that shutdown and reset both restore
  function automatic bdc_pkg::bdc_ctl_regs_t rst_val();
    bdc_pkg::bdc_ctl_regs_t v;
    v        = '0;
    v.mode   = `BDC_RST_MODE;
    v.full_scale_current    = `BDC_RST_IFS;
    v.lo     = `BDC_RST_BRT;
    v.hi     = `BDC_RST_BRT;
    v.pwmc   = `BDC_RST_PWM;
    v.duty_h = `BDC_CODE_MAX;
    return v;
  endfunction

  // Interface is live only with the pin high and the supply settled
  assign i2c_en = hw_enable_pin_in && q.i2c_ok; // RQ1 RQ2

  bdc_i2c_slave u_slave (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .enable_in   (i2c_en),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .sda_out     (sda_out),
    .sda_oe_out  (sda_oe_out),
    .rd_data_in  (rd_data),
    .rd_addr_out (rd_addr),
    .wr_stb_out  (wr_stb),
    .wr_addr_out (wr_addr),
    .wr_data_out (wr_data)
  );

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (rd_addr)
      `BDC_REG_MODE:   rd_data = q.mode;
      `BDC_REG_IFS:    rd_data = q.full_scale_current;
      `BDC_REG_BRT_LO: rd_data = q.lo;
      `BDC_REG_BRT_HI: rd_data = q.hi;
      `BDC_REG_PWM:    rd_data = q.pwmc;
      default:         rd_data = 8'h00;
    endcase
  end

  // Operating state decode
  assign active = hw_enable_pin_in && (q.mode[`BDC_F_STATE] != 2'h0); // RQ5
  assign flash  = q.mode[`BDC_F_FLASH]; // RQ5
  assign pwm_en = q.mode[`BDC_F_PWMEN]; // RQ14

  // Sample divider and timeout limit per rate field; 24 MHz runs at 25 MHz, the nearest divide of the clock
  always_comb begin
    case (q.pwmc[`BDC_F_RATE])
      `BDC_RATE_800K: begin
        smp_lim = 8'(SMP_DIV_08); // RQ15
        tmo_lim = 22'(TMO_CYC_08); // RQ20
      end
      `BDC_RATE_4M: begin
        smp_lim = 8'(SMP_DIV_4);
        tmo_lim = 22'(TMO_CYC_4);
      end
      default: begin
        smp_lim = 8'(SMP_DIV_24);
        tmo_lim = 22'(TMO_CYC_24);
      end
    endcase
  end

  // Exponential curve as 2^(code/236.59) with a straight-line mantissa, scaled by 2047/400
  always_comb begin
    exp_t = 20'(q.code) * `BDC_EXP_K;
    exp_m = 17'({1'b1, exp_t[15:8]}) << exp_t[19:16];
    exp_p = 29'(exp_m) * 29'(`BDC_EXP_GAIN);
    if (q.code == 11'h000) begin
      base = 11'h000; // RQ12
    end else if (!q.mode[`BDC_F_EXP]) begin
      base = q.code; // RQ9 RQ10
    end else if (exp_p[28:16] > 13'(`BDC_CODE_MAX)) begin
      base = `BDC_CODE_MAX; // RQ11
    end else begin
      base = exp_p[26:16]; // RQ11
    end
    // Duty enters only in backlight with PWM dimming on
    eff_duty = (pwm_en && !flash) ? q.duty_h : `BDC_CODE_MAX; // RQ13 RQ16
    prod     = 22'(base) * 22'(eff_duty);
    // Divide by 2047 as x/2048 corrected by x/2^22, exact at both ends
    prod_n   = prod + (prod >> 11) + 22'h00_0001;
    target   = prod_n[21:11]; // RQ10
  end

  // All next-state logic
  always_comb begin
    logic        rise;
    logic        tick;
    logic        hit;
    logic [30:0] trial;
    logic [10:0] qn;
    logic [10:0] hy;
    logic [17:0] rp;
    rise  = 1'b0;
    hit   = 1'b0;
    qn    = q.quo;
    hy    = {8'h00, q.pwmc[`BDC_F_HYST]}; // RQ18
    trial = 31'(q.dvs) << q.bit_i;
    rp    = 18'h0_0000;
    d     = q;

    // Register writes; the code is only rebuilt on the high byte
    if (wr_stb) begin
      case (wr_addr)
        `BDC_REG_MODE:   d.mode = wr_data;
        `BDC_REG_IFS:    d.full_scale_current  = wr_data; // RQ23
        `BDC_REG_BRT_LO: d.lo   = wr_data;
        `BDC_REG_BRT_HI: begin
          d.hi   = wr_data;
          d.code = {wr_data, q.lo[`BDC_F_LSB]}; // RQ6 RQ8
        end
        `BDC_REG_PWM:    d.pwmc = wr_data;
        default: begin
        end
      endcase
    end

    // Supply reset interval before the interface opens
    if (!supply_por_n_in) begin
      d.por_cnt = 16'h0000; // RQ2
      d.i2c_ok  = 1'b0;
    end else if (!q.i2c_ok) begin
      d.por_cnt = q.por_cnt + 16'h0001;
      d.i2c_ok  = (q.por_cnt >= 16'(TRESET_CYC - 1)); // RQ2
    end

    // Sample enable from the clock divider
    tick = (q.smp_cnt >= smp_lim - 8'h01);
    d.smp_cnt = tick ? 8'h00 : q.smp_cnt + 8'h01;

    // High and period counts per input period, measured rising edge to rising edge
    if (tick) begin
      d.pwm_p = pwm_in;
      rise    = pwm_in && !q.pwm_p;
      if (rise) begin
        if (!q.busy && (q.per_cnt != 20'h0_0000)) begin
          d.busy  = 1'b1;
          d.bit_i = 4'hA;
          d.rem   = 31'(q.hi_cnt) * 31'(`BDC_CODE_MAX); // RQ14
          d.dvs   = q.per_cnt;
          d.quo   = 11'h000;
        end
        d.per_cnt = 20'h0_0001;
        d.hi_cnt  = 20'h0_0001;
      end else if (q.per_cnt != 20'hF_FFFF) begin
        d.per_cnt = q.per_cnt + 20'h0_0001;
        d.hi_cnt  = q.hi_cnt + 20'(pwm_in);
      end
    end

    // Bit-serial divide: duty = high * 2047 / period, eleven cycles
    if (q.busy) begin
      if (q.rem >= trial) begin
        d.rem = q.rem - trial;
        qn[q.bit_i] = 1'b1;
      end
      d.quo   = qn;
      d.bit_i = q.bit_i - 4'h1;
      if (q.bit_i == 4'h0) begin
        d.busy = 1'b0;
        // Reversal must clear the hysteresis, a continued move passes at once
        if (qn > q.duty_h) begin
          if (q.dir_up || ((qn - q.duty_h) >= hy)) begin // RQ17
            d.duty_h = qn;
            d.dir_up = 1'b1;
          end
        end else if (qn < q.duty_h) begin
          if (!q.dir_up || ((q.duty_h - qn) >= hy)) begin // RQ17
            d.duty_h = qn;
            d.dir_up = 1'b0;
          end
        end
      end
    end

    // Pulse watchdog, restarted by any sampled edge
    if (!pwm_en) begin
      d.tmo_cnt   = 22'h00_0000;
      d.timed_out = 1'b0;
    end else if (tick && (pwm_in != q.pwm_p)) begin
      d.tmo_cnt   = 22'h00_0000;
      d.timed_out = 1'b0;
    end else if (q.tmo_cnt >= tmo_lim - 22'h00_0001) begin
      d.timed_out = 1'b1; // RQ19 RQ20
    end else begin
      d.tmo_cnt = q.tmo_cnt + 22'h00_0001;
    end

    // LED level: follow target while on, ramp in 64 equal steps after a command turn-off
    d.active_p = active;
    if (!hw_enable_pin_in) begin
      d.level     = 11'h000; // RQ3
      d.ramp_left = 7'h00;
    end else if (active && (q.code != 11'h000)) begin
      d.level     = target;
      d.ramp_left = 7'h00;
    end else if (q.code == 11'h000) begin
      d.level     = 11'h000; // RQ12
      d.ramp_left = 7'h00;
    end else if (q.active_p) begin
      d.ramp_base = q.level; // RQ4
      d.ramp_left = `BDC_RAMP_STEPS;
      d.ramp_cnt  = 16'h0000;
    end else if (q.ramp_left != 7'h00) begin
      hit = (q.ramp_cnt >= 16'(RAMP_STEP_CYC - 1));
      d.ramp_cnt = hit ? 16'h0000 : q.ramp_cnt + 16'h0001;
      if (hit) begin
        d.ramp_left = q.ramp_left - 7'h01;
        rp          = 18'(q.ramp_base) * 18'(q.ramp_left - 7'h01);
        d.level     = rp[16:6]; // RQ4
      end
    end

    // Shutdown puts every register back to default except the supply reset count and the interface gate
    if (!hw_enable_pin_in) begin
      d         = rst_val(); // RQ1
      d.por_cnt = q.por_cnt;
      d.i2c_ok  = q.i2c_ok && supply_por_n_in;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= rst_val();
    end else begin
      q <= d;
    end
  end

  // Outputs from the state register; the mode outputs are also gated directly by the enable pin
  assign led_level_out          = q.level;
  assign full_scale_current_out = q.full_scale_current[`BDC_F_IFS]; // RQ23
  assign sink_enable_out        = (q.level != 11'h000) ? q.full_scale_current[`BDC_F_CHAN] : 3'h0; // RQ12
  assign boost_enable_out       = (q.level != 11'h000) &&
                                  !(pwm_en && !flash && q.timed_out); // RQ12 RQ19
  assign backlight_mode_out     = active && !flash;
  assign flash_mode_out         = active && flash;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  property p_shutdown_regs;
    !hw_enable_pin_in |-> !i2c_en ##1 (q.mode == `BDC_RST_MODE) && (q.code == 11'h000);
  endproperty
  a_shutdown_regs: assert property (p_shutdown_regs) else $error("shutdown kept state"); // RQ1

  property p_por_gate;
    !supply_por_n_in |=> !i2c_en [*2];
  endproperty
  a_por_gate: assert property (p_por_gate) else $error("interface open during supply reset"); // RQ2

  property p_cut_now;
    !hw_enable_pin_in |=> (led_level_out == 11'h000) && !boost_enable_out;
  endproperty
  a_cut_now: assert property (p_cut_now) else $error("current not cut on enable low"); // RQ3

  property p_ramp_down;
    hw_enable_pin_in && $fell(active) && (q.code != 11'h000) && (q.level > 11'h001)
      |=> (led_level_out == $past(led_level_out));
  endproperty
  a_ramp_down: assert property (p_ramp_down) else $error("current dropped without ramp"); // RQ4

  property p_state_decode;
    hw_enable_pin_in |-> (flash_mode_out == q.mode[`BDC_F_FLASH]) &&
      (backlight_mode_out == (q.mode[`BDC_F_STATE] == 2'h1));
  endproperty
  a_state_decode: assert property (p_state_decode) else $error("state decode wrong"); // RQ5

  property p_code_on_high;
    hw_enable_pin_in && !(wr_stb && (wr_addr == `BDC_REG_BRT_HI)) |=> $stable(q.code);
  endproperty
  a_code_on_high: assert property (p_code_on_high) else $error("code changed without high write"); // RQ8

  property p_zero_dark;
    hw_enable_pin_in && (q.code == 11'h000) |=> (sink_enable_out == 3'h0) && !boost_enable_out;
  endproperty
  a_zero_dark: assert property (p_zero_dark) else $error("code zero left LEDs on"); // RQ12

  property p_linear_full;
    active && !q.mode[`BDC_F_EXP] && (eff_duty == `BDC_CODE_MAX) && (q.code != 11'h000)
      |=> (q.level == $past(q.code));
  endproperty
  a_linear_full: assert property (p_linear_full) else $error("linear level wrong"); // RQ10 RQ13

  property p_no_hyst;
    q.busy && (q.bit_i == 4'h0) && (q.pwmc[`BDC_F_HYST] == 3'h0) |=> (q.duty_h == q.quo);
  endproperty
  a_no_hyst: assert property (p_no_hyst) else $error("zero hysteresis held duty"); // RQ17 RQ18

  property p_timeout_boost;
    pwm_en && !flash && q.timed_out |-> !boost_enable_out;
  endproperty
  a_timeout_boost: assert property (p_timeout_boost) else $error("boost on after timeout"); // RQ19

  property p_timeout_bound;
    pwm_en |-> (q.tmo_cnt < tmo_lim);
  endproperty
  a_timeout_bound: assert property (p_timeout_bound) else $error("watchdog overran limit"); // RQ20

  c_flash: cover property (flash_mode_out && (led_level_out != 11'h000));
  c_timeout: cover property ($rose(q.timed_out));
  c_ramp_end: cover property ($fell(q.ramp_left != 7'h00));
  c_duty_done: cover property ($fell(q.busy));

endmodule
`default_nettype wire

/* File: bdc_host_model.sv */
// Host model: serial bus master and PWM source facing the dimming control
`timescale 1ns/100ps
`default_nettype none
module bdc_host_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out,
  output logic      pwm_out
);
  int nack_cnt = 0;
  bit pwm_on   = 1'b0;
  int pcnt     = 0;
  // Idle bus released, PWM low as with its pull-down
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    pwm_out = 1'b0;
  end
  // One bit; data moves one edge after the clock falls, never with it
  task automatic bitx(input logic b, output logic s);
    @(posedge clk_in);
    sda_out <= b;
    repeat (3) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    s = sda_in;
    scl_out <= 1'b0;
  endtask
  // Byte, most significant bit first, then the acknowledge slot
  task automatic bytex(input logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(v[i], s);
    bitx(1'b1, s);
    if (s !== 1'b0) nack_cnt++;
  endtask
  // Start condition from an idle bus, leaves the clock low
  task automatic sta;
    @(posedge clk_in);
    sda_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    scl_out <= 1'b0;
  endtask
  // Stop condition, leaves both lines released
  task automatic sto;
    @(posedge clk_in);
    sda_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    sda_out <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask
  // Whole register write: start, device address, pointer, data, stop
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
    sta();
    bytex({dev, 1'b0});
    bytex(a);
    bytex(d);
    sto();
  endtask
  // Register read: set the pointer, then a new start and one byte closed by a NACK
  task automatic rd(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] v);
    logic s;
    sta();
    bytex({dev, 1'b0});
    bytex(a);
    sto();
    sta();
    bytex({dev, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      v[i] = s;
    end
    bitx(1'b1, s);
    sto();
  endtask
  // 50 kHz source at one quarter duty, too fast for full resolution at any sample rate
  always @(posedge clk_in) begin
    pcnt    <= (pcnt == 3999) ? 0 : pcnt + 1;
    pwm_out <= pwm_on && (pcnt < 1000);
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the backlight dimming control
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk_in     = 1'b0;
  logic        rst_in     = 1'b1;
  logic        en         = 1'b1;
  logic        por_n      = 1'b1;
  wire logic   scl, sda_m, pwm, sda_oe, sda_w;
  logic [10:0] lvl;
  logic [4:0]  fsc;
  logic [2:0]  sinks;
  logic        boost, bl, fl;
  logic [7:0]  lo, hi;
  logic [10:0] held;
  logic [7:0]  rv;
  int          err_total  = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  // Open drain data line with pull-up
  assign sda_w = sda_m & ~sda_oe;
  always #2.5 clk_in = ~clk_in;
  bdc_ctl #(.TRESET_CYC(20), .TMO_CYC_24(6000), .TMO_CYC_4(6000), .TMO_CYC_08(6000),
    .RAMP_STEP_CYC(4)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .hw_enable_pin_in(en), .supply_por_n_in(por_n),
    .scl_in(scl), .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe), .pwm_in(pwm),
    .led_level_out(lvl), .full_scale_current_out(fsc), .sink_enable_out(sinks),
    .boost_enable_out(boost), .backlight_mode_out(bl), .flash_mode_out(fl));
  bdc_host_model host_u (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl),
    .sda_out(sda_m), .pwm_out(pwm));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Returns the expectation when within tolerance, else the raw value
  function automatic logic [15:0] near(input logic [10:0] g, input int e, input int t);
    return (^g !== 1'bx && int'(g) - e <= t && e - int'(g) <= t) ? 16'(e) : 16'(g);
  endfunction
  function automatic int exp_lvl(input int c);
    real r = (1.002931237 ** c) * 2047.0 / 400.0;
    return (c == 0) ? 0 : (r > 2047.0) ? 2047 : int'(r);
  endfunction
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host_u.wr(7'h36, a, d);
  endtask
  task automatic done(input string s);
    $display("test %s finished, mismatches %0d", s, err_total);
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h6620));
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (30) @(posedge clk_in);
    chk({bl, fl, lvl}, 0);
    chk(fsc, 5'h13);
    done("reset");
    w(8'h02, 8'h01);
    chk({bl, fl}, 2);
    for (int i = 0; i < 5; i++) begin
      lo = 8'($urandom);
      hi = (i == 0) ? 8'hFF : 8'($urandom);
      held = lvl;
      w(8'h06, lo);
      chk(lvl, held);
      w(8'h07, hi);
      chk({sinks, lvl}, {({hi, lo[2:0]} != 0) ? 3'h7 : 3'h0, hi, lo[2:0]});
    end
    w(8'h06, 8'h00);
    w(8'h07, 8'h00);
    chk({boost, sinks, lvl}, 0);
    w(8'h02, 8'h05);
    w(8'h07, 8'h80);
    chk(near(lvl, exp_lvl(1024), 6), 16'(exp_lvl(1024)));
    w(8'h07, 8'hFF);
    chk(lvl, 16'h07FF);
    done("mapping");
    w(8'h02, 8'h01);
    w(8'h02, 8'h00);
    chk(16'(lvl > 0 && lvl <= 2040), 1);
    repeat (300) @(posedge clk_in);
    chk(lvl, 0);
    w(8'h03, 8'h2A);
    w(8'h02, 8'h01);
    chk({fsc, sinks}, {5'h05, 3'h2});
    en <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chk({bl, lvl}, 0);
    @(posedge clk_in);
    en <= 1'b1;
    repeat (30) @(posedge clk_in);
    chk(fsc, 5'h13);
    // Supply reset pulse: a write sent at once must find the interface closed
    por_n <= 1'b0;
    @(posedge clk_in);
    por_n <= 1'b1;
    w(8'h03, 8'h2A);
    host_u.rd(7'h36, 8'h03, rv);
    chk(rv, 8'h9F);
    done("enable");
    w(8'h08, 8'hC0);
    w(8'h06, 8'h07);
    w(8'h07, 8'hFF);
    w(8'h02, 8'h11);
    host_u.pwm_on <= 1'b1;
    repeat (16000) @(posedge clk_in);
    chk(near(lvl, 511, 4), 511);
    chk(boost, 1);
    w(8'h02, 8'h12);
    chk(lvl, 16'h07FF);
    w(8'h02, 8'h11);
    host_u.pwm_on <= 1'b0;
    repeat (8000) @(posedge clk_in);
    chk(boost, 0);
    chk(host_u.nack_cnt, 3);
    done("pwm");
    summarize();
  end
endmodule
`default_nettype wire
